// ==== cgi_pkg.sv ====
// shared constants of the clock generator interrupt and status logic
// assumes a 32-bit apb slave; register indices map to byte address 4*index
package cgi_pkg;

  localparam int unsigned SRC_W = 8;
  localparam int unsigned REF_W = 4;
  localparam int unsigned ADDR_W = 8;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [7:0] IDX_LIVE = 8'h0d;
  localparam logic [7:0] IDX_MASK = 8'h0e;
  localparam logic [7:0] IDX_POL = 8'h0f;
  localparam logic [7:0] IDX_FLAGS = 8'h10;
  localparam logic [7:0] IDX_CTRL = 8'h11;
  localparam logic [7:0] IDX_REFST = 8'h12;
  localparam logic [7:0] IDX_DRV = 8'h13;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h14;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h15;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction : byte_addr

  // ==========================================================
  // source bit positions, shared by live, mask, polarity and flags
  localparam int unsigned B_PLL1_LOCK_LOSS = 7;
  localparam int unsigned B_PLL1_INPUT_LOSS = 6;
  localparam int unsigned B_PLL1_CAL = 5;
  localparam int unsigned B_PLL2_LOCK_LOSS = 4;
  localparam int unsigned B_PLL2_INPUT_LOSS = 3;
  localparam int unsigned B_PLL2_CAL = 2;
  localparam int unsigned B_PLL1_REF_SWITCH = 1;
  localparam int unsigned B_PLL2_REF_SWITCH = 0;

  // control register fields
  localparam int unsigned B_INT_EN = 0;
  localparam int unsigned B_AND_SEL = 1;

  // reference status fields, valid indicators sit in [7:4]
  localparam int unsigned B_REF_LSB = 4;

  // status driver control fields
  localparam int unsigned B_B_LIMIT = 5;
  localparam int unsigned B_A_LIMIT = 4;
  localparam int unsigned B_DRV_RSVD_HI = 3;
  localparam int unsigned B_DRV_RSVD_LO = 2;
  localparam int unsigned B_B_OPEN_DRAIN = 1;
  localparam int unsigned B_A_OPEN_DRAIN = 0;

  // bus interrupt status fields
  localparam int unsigned B_IRQ_SIGNALLED = 0;
  localparam int unsigned B_IRQ_FLAG_SET = 1;
  localparam int unsigned IRQ_W = 2;

  // ==========================================================
  // reset values, and the all-ones pattern used by the and combine
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [5:0] RST_DRV = 6'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;

endpackage : cgi_pkg

// ==== cgi_src_sync.sv ====
// two-stage synchroniser with one extra stage for edge detection
// assumes asynchronous level inputs; out_prev lags out_sync by one clk
`timescale 1ns/1ps
module cgi_src_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] out_sync,
  output logic [W-1:0] out_prev
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta;
      // meta feeds only the second stage
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta <= 1'b0;
          out_sync[g] <= 1'b0;
          out_prev[g] <= 1'b0;
        end else begin
          meta <= async_in[g];
          out_sync[g] <= meta;
          out_prev[g] <= out_sync[g];
        end
      end
    end
  endgenerate

endmodule : cgi_src_sync

// ==== cgi_top.sv ====
// interrupt flag, combine and status pin logic of a two-pll clock generator
// assumes apb master on clk, asynchronous source levels from pll logic
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module cgi_top #(
  parameter int unsigned ADDR_W = cgi_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cgi_pkg::SRC_W-1:0] source_level,
  input wire logic [cgi_pkg::REF_W-1:0] ref_valid_level,
  output logic status_pin_a,
  output logic status_pin_a_oe_n,
  output logic status_pin_b,
  output logic status_pin_b_oe_n,
  output logic status_a_current_limit,
  output logic status_b_current_limit,
  output logic irq
);

  localparam int unsigned SW = cgi_pkg::SRC_W;

  // ==========================================================
  // synchronisers
  logic [SW-1:0] raw_sync;
  logic [SW-1:0] raw_prev;
  logic [cgi_pkg::REF_W-1:0] ref_sync;

  cgi_src_sync #(.W(SW)) u_src_sync (
    .clk(clk),
    .reset(reset),
    .async_in(source_level),
    .out_sync(raw_sync),
    .out_prev(raw_prev)
  );

  cgi_src_sync #(.W(cgi_pkg::REF_W)) u_ref_sync (
    .clk(clk),
    .reset(reset),
    .async_in(ref_valid_level),
    .out_sync(ref_sync),
    .out_prev()
  );

  // ==========================================================
  // source shaping and edge detection
  wire [SW-1:0] loss_kill =
    ({SW{raw_sync[cgi_pkg::B_PLL1_INPUT_LOSS]}}
      & (SW'(1) << cgi_pkg::B_PLL1_LOCK_LOSS))
    | ({SW{raw_sync[cgi_pkg::B_PLL2_INPUT_LOSS]}}
      & (SW'(1) << cgi_pkg::B_PLL2_LOCK_LOSS));
  wire [SW-1:0] loss_kill_prev =
    ({SW{raw_prev[cgi_pkg::B_PLL1_INPUT_LOSS]}}
      & (SW'(1) << cgi_pkg::B_PLL1_LOCK_LOSS))
    | ({SW{raw_prev[cgi_pkg::B_PLL2_INPUT_LOSS]}}
      & (SW'(1) << cgi_pkg::B_PLL2_LOCK_LOSS));
  wire [SW-1:0] src_now = raw_sync & ~loss_kill;
  wire [SW-1:0] src_prev = raw_prev & ~loss_kill_prev;

  logic [SW-1:0] live_source_status;
  logic [SW-1:0] mask;
  logic [SW-1:0] edge_polarity_select;
  logic [SW-1:0] flags;
  logic [1:0] ctrl;
  logic [5:0] drv;
  logic [cgi_pkg::IRQ_W-1:0] irq_status;
  logic [cgi_pkg::IRQ_W-1:0] irq_mask;
  logic status_sig;

  wire int_en = ctrl[cgi_pkg::B_INT_EN];
  wire and_sel = ctrl[cgi_pkg::B_AND_SEL];
  wire [SW-1:0] rise = src_now & ~src_prev;
  wire [SW-1:0] fall = ~src_now & src_prev;
  wire [SW-1:0] hit_vec = {SW{int_en}}
    & ((edge_polarity_select & rise)
      | (~edge_polarity_select & fall));

  // ==========================================================
  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire sel_live = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_LIVE);
  wire sel_mask = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_MASK);
  wire sel_pol = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_POL);
  wire sel_flags = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_FLAGS);
  wire sel_ctrl = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_CTRL);
  wire sel_refst = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_REFST);
  wire sel_drv = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_DRV);
  wire sel_irqs = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_IRQ_STATUS);
  wire sel_irqm = paddr == cgi_pkg::byte_addr(cgi_pkg::IDX_IRQ_MASK);
  wire mapped = sel_live | sel_mask | sel_pol | sel_flags | sel_ctrl
    | sel_refst | sel_drv | sel_irqs | sel_irqm;
  wire wr_flags = wr & sel_flags;

  wire [7:0] drv_rd = {2'b00, drv};
  wire [7:0] ref_rd = {ref_sync, 4'h0};
  wire [7:0] rd_byte =
    ({8{sel_live}} & live_source_status)
    | ({8{sel_mask}} & mask)
    | ({8{sel_pol}} & edge_polarity_select)
    | ({8{sel_flags}} & flags)
    | ({8{sel_ctrl}} & {6'h00, ctrl})
    | ({8{sel_refst}} & ref_rd)
    | ({8{sel_drv}} & drv_rd)
    | ({8{sel_irqs}} & {6'h00, irq_status})
    | ({8{sel_irqm}} & {6'h00, irq_mask});

  // one wait-free access phase: pready rises in the setup cycle's wake
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // flags: zero bits of a write clear, set beats clear
  wire [SW-1:0] clr_vec = {SW{wr_flags}} & ~pwdata[SW-1:0];
  wire [SW-1:0] next_flags = (flags & ~clr_vec) | hit_vec;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags <= cgi_pkg::RST_FLAGS;
      live_source_status <= '0;
    end else begin
      flags <= next_flags;
      live_source_status <= src_now;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask <= cgi_pkg::RST_MASK;
      edge_polarity_select <= cgi_pkg::RST_POL;
      ctrl <= cgi_pkg::RST_CTRL;
      drv <= cgi_pkg::RST_DRV;
      irq_mask <= '0;
    end else if (wr) begin
      if (sel_mask) mask <= pwdata[SW-1:0];
      if (sel_pol) edge_polarity_select <= pwdata[SW-1:0];
      if (sel_ctrl) ctrl <= pwdata[1:0];
      if (sel_drv) drv <= pwdata[5:0];
      if (sel_irqm) irq_mask <= pwdata[cgi_pkg::IRQ_W-1:0];
    end
  end

  // ==========================================================
  // combine and status pins
  wire [SW-1:0] unmasked = flags & ~mask;
  wire all_hit = ((flags | mask) == cgi_pkg::ALL_ONES)
    & (mask != cgi_pkg::ALL_ONES);
  wire any_hit = |unmasked;
  wire next_status = int_en & (and_sel ? all_hit : any_hit);
  wire od_a = drv[cgi_pkg::B_A_OPEN_DRAIN];
  wire od_b = drv[cgi_pkg::B_B_OPEN_DRAIN];

  // open drain only pulls low; high is left to the board pull-up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_sig <= 1'b0;
      status_pin_a <= 1'b0;
      status_pin_a_oe_n <= 1'b0;
      status_pin_b <= 1'b0;
      status_pin_b_oe_n <= 1'b0;
      status_a_current_limit <= 1'b0;
      status_b_current_limit <= 1'b0;
    end else begin
      status_sig <= next_status;
      status_pin_a <= od_a ? 1'b0 : next_status;
      status_pin_a_oe_n <= od_a & next_status;
      status_pin_b <= od_b ? 1'b0 : next_status;
      status_pin_b_oe_n <= od_b & next_status;
      status_a_current_limit <= drv[cgi_pkg::B_A_LIMIT];
      status_b_current_limit <= drv[cgi_pkg::B_B_LIMIT];
    end
  end

  // ==========================================================
  // bus interrupt: write one to clear, set wins
  wire [cgi_pkg::IRQ_W-1:0] irq_set = {|(hit_vec & ~flags),
    next_status & ~status_sig};
  wire [cgi_pkg::IRQ_W-1:0] irq_clr =
    {cgi_pkg::IRQ_W{wr & sel_irqs}} & pwdata[cgi_pkg::IRQ_W-1:0];
  wire [cgi_pkg::IRQ_W-1:0] next_irq_status =
    (irq_status & ~irq_clr) | irq_set;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & ~irq_mask);
    end
  end

  // ==========================================================
  // assertions
  sequence s_clear_write;
    wr_flags && (hit_vec == 8'h00);
  endsequence

  sequence s_edge_during_clear;
    wr_flags && (hit_vec != 8'h00);
  endsequence

  property p_flag_set;
    @(posedge clk) disable iff (reset)
      (hit_vec != 8'h00) |=> ((flags & $past(hit_vec)) == $past(hit_vec));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("edge did not latch flag");

  property p_no_set_disabled;
    @(posedge clk) disable iff (reset)
      !int_en |=> ((flags & ~$past(flags)) == 8'h00);
  endproperty
  a_no_set_disabled: assert property (p_no_set_disabled)
    else $error("flag set while disabled");

  property p_sticky;
    @(posedge clk) disable iff (reset)
      !wr_flags |=> (($past(flags) & ~flags) == 8'h00);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag cleared without write");

  property p_clear_zero;
    @(posedge clk) disable iff (reset)
      s_clear_write |=> (flags == ($past(flags) & $past(pwdata[7:0])));
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clearing write wrong");

  property p_set_wins;
    @(posedge clk) disable iff (reset)
      s_edge_during_clear
        |=> ((flags & $past(hit_vec)) == $past(hit_vec));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("edge lost during clear");

  property p_quiet_disabled;
    @(posedge clk) disable iff (reset)
      !int_en |=> !status_sig ##0 status_pin_a_oe_n == 1'b0;
  endproperty
  a_quiet_disabled: assert property (p_quiet_disabled)
    else $error("status signalled while disabled");

  property p_or_mode;
    @(posedge clk) disable iff (reset)
      int_en && !and_sel && (unmasked != 8'h00) |=> status_sig;
  endproperty
  a_or_mode: assert property (p_or_mode)
    else $error("or combine missed");

  property p_and_mode;
    @(posedge clk) disable iff (reset)
      and_sel && ((flags | mask) != 8'hff) |=> !status_sig;
  endproperty
  a_and_mode: assert property (p_and_mode)
    else $error("and combine fired early");

  property p_mask_all;
    @(posedge clk) disable iff (reset)
      !and_sel && (unmasked == 8'h00) |=> !status_sig;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("masked source reached pin");

  property p_loss_priority;
    @(posedge clk) disable iff (reset)
      live_source_status[6] |-> !live_source_status[7];
  endproperty
  a_loss_priority: assert property (p_loss_priority)
    else $error("lock loss shown with input loss");

  property p_live_tracks;
    @(posedge clk) disable iff (reset)
      !int_en |=> (live_source_status == $past(src_now));
  endproperty
  a_live_tracks: assert property (p_live_tracks)
    else $error("live status stale");

endmodule : cgi_top

// ==== cgi_host_pins.sv ====
// host side pin model: resolves the two status wires seen by the host
// assumes cgi_top status outputs, oe_n low while the block drives a pin
`timescale 1ns/1ps
module cgi_host_pins (
  input wire logic pin_a,
  input wire logic pin_a_oe_n,
  input wire logic pin_b,
  input wire logic pin_b_oe_n,
  output logic level_a,
  output logic level_b
);
  // ==========================================================
  // wire resolution
  // a released open-drain wire goes to the board pull-up, never to x
  assign level_a = pin_a_oe_n ? 1'b1 : pin_a;
  assign level_b = pin_b_oe_n ? 1'b1 : pin_b;
endmodule : cgi_host_pins

// ==== tb_top.sv ====
// self-checking bench of the clock generator interrupt and status logic
// assumes cgi_top with an apb master on clk and the host pin model
`timescale 1ns/1ps
module tb_top;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, source_level;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0] ref_valid_level;
  logic pa, pa_oe_n, pb, pb_oe_n, lim_a, lim_b, irq, lvl_a, lvl_b;
  int n_errors, cmp_count;
  // ctrl[17:16], driver[15:8], mask[7:0] against flags 8'h6f
  logic [17:0] cmb [8] = '{18'h10000, 18'h100ff, 18'h30390, 18'h30380,
    18'h300ff, 18'h00000, 18'h20190, 18'h1020f};
  logic [7:0] rst_idx [8] = '{cgi_pkg::IDX_LIVE, cgi_pkg::IDX_MASK,
    cgi_pkg::IDX_POL, cgi_pkg::IDX_FLAGS, cgi_pkg::IDX_CTRL,
    cgi_pkg::IDX_DRV, cgi_pkg::IDX_IRQ_STATUS, cgi_pkg::IDX_IRQ_MASK};

  cgi_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .source_level(source_level),
    .ref_valid_level(ref_valid_level), .status_pin_a(pa),
    .status_pin_a_oe_n(pa_oe_n), .status_pin_b(pb),
    .status_pin_b_oe_n(pb_oe_n), .status_a_current_limit(lim_a),
    .status_b_current_limit(lim_b), .irq(irq));
  cgi_host_pins host (.pin_a(pa), .pin_a_oe_n(pa_oe_n), .pin_b(pb),
    .pin_b_oe_n(pb_oe_n), .level_a(lvl_a), .level_b(lvl_b));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // zero wait states expected, but the wait is bounded, not assumed
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      test_done();
    end
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask : rdc

  // two sync stages and the flag register need three edges; six leaves margin
  task automatic src(input logic [7:0] v);
    @(posedge clk);
    source_level <= v;
    repeat (6) @(posedge clk);
  endtask : src

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic [7:0] live_of(input logic [7:0] s);
    return s & ~{s[6], 2'b00, s[3], 4'h0};
  endfunction : live_of

  function automatic logic pin_of(input logic [7:0] f, input logic [7:0] m,
                                  input logic [1:0] c);
    if (!c[0]) return 1'b0;
    if (c[1]) return ((f | m) == 8'hff) && (m != 8'hff);
    return |(f & ~m);
  endfunction : pin_of

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] r;
    logic p;
    int i;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    source_level = 8'h00;
    ref_valid_level = 4'h0;
    n_errors = 0;
    cmp_count = 0;
    seed = 32'h67c5e77a;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 8; i++) rdc(rst_idx[i], 8'h00);
    apb(1'b0, 8'h3f, 8'h00);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("reset values and decode done");
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      r = seed[7:0];
      wr(cgi_pkg::IDX_MASK, r);
      rdc(cgi_pkg::IDX_MASK, r);
      wr(cgi_pkg::IDX_POL, ~r);
      rdc(cgi_pkg::IDX_POL, ~r);
      wr(cgi_pkg::IDX_CTRL, r);
      rdc(cgi_pkg::IDX_CTRL, r & 8'h03);
      wr(cgi_pkg::IDX_DRV, r);
      rdc(cgi_pkg::IDX_DRV, r & 8'h3f);
      chk({30'h0, lim_b, lim_a}, {30'h0, r[5:4]});
    end
    wr(cgi_pkg::IDX_MASK, 8'h00);
    wr(cgi_pkg::IDX_DRV, 8'h00);
    wr(cgi_pkg::IDX_CTRL, 8'h00);
    wr(cgi_pkg::IDX_POL, 8'hff);
    seed = xs(seed);
    r = seed[7:0] | 8'h48;
    src(r);
    rdc(cgi_pkg::IDX_LIVE, live_of(r));
    src(8'h00);
    rdc(cgi_pkg::IDX_FLAGS, 8'h00);
    chk({30'h0, lvl_b, lvl_a}, 32'h0000_0000);
    $display("register access and disabled flags done");
    wr(cgi_pkg::IDX_CTRL, 8'h01);
    for (i = 0; i < 16; i++) begin
      r = 8'h01 << i[2:0];
      wr(cgi_pkg::IDX_POL, i[3] ? 8'h00 : 8'hff);
      src(r);
      rdc(cgi_pkg::IDX_FLAGS, i[3] ? 8'h00 : r);
      src(8'h00);
      rdc(cgi_pkg::IDX_FLAGS, r);
      chk({30'h0, lvl_b, lvl_a}, 32'h0000_0003);
      wr(cgi_pkg::IDX_FLAGS, 8'hff);
      rdc(cgi_pkg::IDX_FLAGS, r);
      wr(cgi_pkg::IDX_FLAGS, 8'h00);
      rdc(cgi_pkg::IDX_FLAGS, 8'h00);
    end
    $display("edge flags done");
    wr(cgi_pkg::IDX_POL, 8'hff);
    // bit 1 edge reaches the flag on the very edge the clearing write lands
    src(8'h01);
    @(posedge clk);
    source_level <= 8'h03;
    wr(cgi_pkg::IDX_FLAGS, 8'h00);
    rdc(cgi_pkg::IDX_FLAGS, 8'h02);
    src(8'h00);
    wr(cgi_pkg::IDX_FLAGS, 8'h00);
    rdc(cgi_pkg::IDX_FLAGS, 8'h00);
    src(8'hff);
    src(8'h00);
    rdc(cgi_pkg::IDX_FLAGS, 8'h6f);
    for (i = 0; i < 8; i++) begin
      wr(cgi_pkg::IDX_DRV, cmb[i][15:8]);
      wr(cgi_pkg::IDX_MASK, cmb[i][7:0]);
      wr(cgi_pkg::IDX_CTRL, {6'h00, cmb[i][17:16]});
      repeat (3) @(posedge clk);
      p = pin_of(8'h6f, cmb[i][7:0], cmb[i][17:16]);
      chk({30'h0, lvl_b, lvl_a}, {30'h0, p, p});
      chk({30'h0, pb_oe_n, pa_oe_n},
        {30'h0, cmb[i][9:8] & {p, p}});
    end
    $display("combine and pin drive done");
    wr(cgi_pkg::IDX_DRV, 8'h00);
    wr(cgi_pkg::IDX_MASK, 8'h00);
    wr(cgi_pkg::IDX_CTRL, 8'h01);
    wr(cgi_pkg::IDX_FLAGS, 8'h00);
    wr(cgi_pkg::IDX_IRQ_MASK, 8'h03);
    wr(cgi_pkg::IDX_IRQ_STATUS, 8'h03);
    rdc(cgi_pkg::IDX_IRQ_STATUS, 8'h00);
    src(8'h01);
    rdc(cgi_pkg::IDX_IRQ_STATUS, 8'h03);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(cgi_pkg::IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    src(8'h00);
    wr(cgi_pkg::IDX_FLAGS, 8'h00);
    wr(cgi_pkg::IDX_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("bus interrupt done");
    seed = xs(seed);
    r = {seed[3:0], 4'h0};
    ref_valid_level <= seed[3:0];
    repeat (4) @(posedge clk);
    rdc(cgi_pkg::IDX_REFST, r);
    wr(cgi_pkg::IDX_REFST, 8'hff);
    rdc(cgi_pkg::IDX_REFST, r);
    $display("reference status done");
    test_done();
  end
endmodule : tb_top
